// ==== hw/ebam_pkg.sv ====
// Purpose: shared constants, op codes and decoders of the 8-bit alu datapath
// Assumes: single clock, registers reached over avalon-mm, byte addresses
// Notes: operand a is the destination, operand b the source_reg or constant
`default_nettype none
package ebam_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int BUS_W = 32;
  localparam int FLAGS_W = 6;
  localparam int OP_W = 5;
  localparam logic [ADDR_W-1:0] REG_OPA = 5'h00;
  localparam logic [ADDR_W-1:0] REG_OPB = 5'h04;
  localparam logic [ADDR_W-1:0] REG_OPA_HI = 5'h08;
  localparam logic [ADDR_W-1:0] REG_CMD = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_RESULT = 5'h10;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 5'h14;
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [FLAGS_W-1:0] RST_FLAGS = 6'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] MIN_SIGNED = 8'h80;
  localparam logic [7:0] POS_LIMIT = 8'h7f;
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_DOUBLE = 2'h2;

  typedef enum logic [OP_W-1:0] {
    OP_ADD = 5'h00,
    OP_ADD_CARRY = 5'h01,
    OP_WORD_ADD_IMMEDIATE = 5'h02,
    OP_SUBTRACT = 5'h03,
    OP_SUBTRACT_CONSTANT = 5'h04,
    OP_SUBTRACT_WITH_BORROW = 5'h05,
    OP_SUBTRACT_CONSTANT_WITH_BORROW = 5'h06,
    OP_WORD_SUBTRACT_IMMEDIATE = 5'h07,
    OP_AND = 5'h08,
    OP_AND_CONSTANT = 5'h09,
    OP_OR = 5'h0a,
    OP_OR_CONSTANT = 5'h0b,
    OP_EXCLUSIVE_OR = 5'h0c,
    OP_BITWISE_INVERT = 5'h0d,
    OP_SIGN_FLIP = 5'h0e,
    OP_SET_BITS_BY_MASK = 5'h0f,
    OP_CLEAR_BITS_BY_MASK = 5'h10,
    OP_INCREMENT = 5'h11,
    OP_MINUS_ONE = 5'h12,
    OP_SELF_AND_TEST = 5'h13,
    OP_ZERO_REGISTER = 5'h14,
    OP_FILL_ONES = 5'h15,
    OP_UNSIGNED_PRODUCT = 5'h16,
    OP_SIGNED_PRODUCT = 5'h17,
    OP_MIXED_SIGN_PRODUCT = 5'h18,
    OP_FRACTIONAL_UNSIGNED_PRODUCT = 5'h19,
    OP_FRACTIONAL_SIGNED_PRODUCT = 5'h1a,
    OP_FRACTIONAL_MIXED_PRODUCT = 5'h1b
  } ebam_op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } ebam_state_e;

  function automatic logic ebam_is_product(input ebam_op_e op);
    ebam_is_product = (op >= OP_UNSIGNED_PRODUCT) &&
                      (op <= OP_FRACTIONAL_MIXED_PRODUCT);
  endfunction

  function automatic logic ebam_is_word(input ebam_op_e op);
    ebam_is_word = (op == OP_WORD_ADD_IMMEDIATE) ||
                   (op == OP_WORD_SUBTRACT_IMMEDIATE);
  endfunction

  function automatic logic [1:0] ebam_cycles(input ebam_op_e op);
    ebam_cycles = (ebam_is_product(op) || ebam_is_word(op)) ?
                  CYC_DOUBLE : CYC_SINGLE;
  endfunction

  function automatic logic ebam_signed_a(input ebam_op_e op);
    ebam_signed_a = (op == OP_SIGNED_PRODUCT) ||
                    (op == OP_MIXED_SIGN_PRODUCT) ||
                    (op == OP_FRACTIONAL_SIGNED_PRODUCT) ||
                    (op == OP_FRACTIONAL_MIXED_PRODUCT);
  endfunction

  function automatic logic ebam_signed_b(input ebam_op_e op);
    ebam_signed_b = (op == OP_SIGNED_PRODUCT) ||
                    (op == OP_FRACTIONAL_SIGNED_PRODUCT);
  endfunction

  function automatic logic ebam_is_fraction(input ebam_op_e op);
    ebam_is_fraction = (op >= OP_FRACTIONAL_UNSIGNED_PRODUCT) &&
                       (op <= OP_FRACTIONAL_MIXED_PRODUCT);
  endfunction

  function automatic logic ebam_is_sub(input ebam_op_e op);
    ebam_is_sub = (op == OP_SUBTRACT) || (op == OP_SUBTRACT_CONSTANT) ||
                  (op == OP_SUBTRACT_WITH_BORROW) ||
                  (op == OP_SUBTRACT_CONSTANT_WITH_BORROW) ||
                  (op == OP_SIGN_FLIP) || (op == OP_MINUS_ONE);
  endfunction

  function automatic logic ebam_takes_carry(input ebam_op_e op);
    ebam_takes_carry = (op == OP_ADD_CARRY) ||
                       (op == OP_SUBTRACT_WITH_BORROW) ||
                       (op == OP_SUBTRACT_CONSTANT_WITH_BORROW);
  endfunction

  // carry out of bit 3, for a sum or for a difference
  function automatic logic ebam_half_flag(input logic sub, input logic a,
                                          input logic b, input logic r);
    ebam_half_flag = sub ? ((~a & b) | (b & r) | (r & ~a)) :
                           ((a & b) | (b & ~r) | (~r & a));
  endfunction

  // two's complement overflow from the sign bits
  function automatic logic ebam_over_flag(input logic sub, input logic a,
                                          input logic b, input logic r);
    ebam_over_flag = sub ? ((a & ~b & ~r) | (~a & b & r)) :
                           ((a & b & ~r) | (~a & ~b & r));
  endfunction
endpackage
`default_nettype wire

// ==== hw/ebam_multiplier.sv ====
// Purpose: registered 8x8 multiplier with signed, mixed and fractional modes
// Assumes: operands stable for the cycle before the product is used
// Notes: carry is bit 15 of the product before the fractional shift
`default_nettype none
module ebam_multiplier #(
  parameter int WIDTH = ebam_pkg::DATA_W
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] factor_a_i,
  input wire logic [WIDTH-1:0] factor_b_i,
  input wire logic a_signed_i,
  input wire logic b_signed_i,
  input wire logic fractional_i,
  output logic [2*WIDTH-1:0] product_o,
  output logic carry_o
);
  import ebam_pkg::*;

  generate
    if (WIDTH != DATA_W)
    begin : g_bad_width
      $error("multiplier width must equal the datapath width");
    end
  endgenerate

  logic signed [WIDTH:0] ext_a;
  logic signed [WIDTH:0] ext_b;
  logic signed [2*WIDTH+1:0] full;
  logic [2*WIDTH-1:0] raw;
  logic [2*WIDTH-1:0] shaped;

  assign ext_a = $signed({a_signed_i & factor_a_i[WIDTH-1], factor_a_i});
  assign ext_b = $signed({b_signed_i & factor_b_i[WIDTH-1], factor_b_i});
  assign full = ext_a * ext_b;
  assign raw = full[2*WIDTH-1:0];
  assign shaped = fractional_i ? {raw[2*WIDTH-2:0], 1'b0} : raw;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      product_o <= '0;
      carry_o <= 1'b0;
    end
    else
    begin
      product_o <= shaped;
      carry_o <= raw[2*WIDTH-1];
    end
  end
endmodule
`default_nettype wire

// ==== hw/ebam_alu.sv ====
// Purpose: alu and multiplier datapath driven over avalon-mm registers
// Assumes: master holds each request until waitrequest is seen low
// Notes: a command write stalls the bus for the operation's own cycles
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`default_nettype none
module ebam_alu (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [ebam_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ebam_pkg::BUS_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [ebam_pkg::BUS_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  import ebam_pkg::*;

  ebam_state_e state_q, state_d;
  ebam_op_e op_q, new_op;
  logic [1:0] cnt_q, cnt_d;
  logic wait_d;
  logic [7:0] opa_q, opb_q, opa_hi_q;
  logic [FLAGS_W-1:0] flags_q, flg_d;
  logic [15:0] result_q, res_d;
  logic wb8, wb16, upd_zn, keep_z;
  logic [15:0] product;
  logic prod_carry;
  logic [BUS_W-1:0] rd_mux;

  // bus decode
  wire accept = avs_waitrequest_o && (avs_read_i || avs_write_i) &&
                (state_q == ST_IDLE);
  wire cmd_start = accept && avs_write_i && avs_byteenable_i[0] &&
                   (avs_address_i == REG_CMD);
  wire commit = (state_q == ST_EXEC) && (cnt_q == 2'h0);
  wire finish_wr = !avs_waitrequest_o && avs_write_i &&
                   avs_byteenable_i[0];
  assign new_op = ebam_op_e'(avs_writedata_i[OP_W-1:0]);

  // operand selection for the shared 8-bit adder
  wire is_sub = ebam_is_sub(op_q);
  wire use_cin = ebam_takes_carry(op_q);
  wire step = (op_q == OP_INCREMENT) || (op_q == OP_MINUS_ONE);
  wire [7:0] add_a = (op_q == OP_SIGN_FLIP) ? RST_BYTE : opa_q;
  wire [7:0] add_b = step ? 8'h01 :
                     (op_q == OP_SIGN_FLIP) ? opa_q : opb_q;
  wire [8:0] cin9 = {8'h00, use_cin & flags_q[FLG_C]};
  wire [8:0] sum9 = is_sub ?
                    9'({1'b0, add_a} - {1'b0, add_b} - cin9) :
                    9'({1'b0, add_a} + {1'b0, add_b} + cin9);
  wire [7:0] r8 = sum9[7:0];
  wire h_bit = ebam_half_flag(is_sub, add_a[3], add_b[3], r8[3]);
  wire v_bit = ebam_over_flag(is_sub, add_a[7], add_b[7], r8[7]);

  // 16-bit pair arithmetic for the word operations
  wire w_sub = (op_q == OP_WORD_SUBTRACT_IMMEDIATE);
  wire [15:0] pair = {opa_hi_q, opa_q};
  wire [15:0] w16 = w_sub ? 16'(pair - {8'h00, opb_q}) :
                            16'(pair + {8'h00, opb_q});
  wire w_c = w_sub ? (w16[15] & ~opa_hi_q[7]) : (~w16[15] & opa_hi_q[7]);
  wire w_v = w_sub ? (opa_hi_q[7] & ~w16[15]) : (~opa_hi_q[7] & w16[15]);

  ebam_multiplier #(
    .WIDTH(DATA_W)
  ) u_prod (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .factor_a_i(opa_q),
    .factor_b_i(opb_q),
    .a_signed_i(ebam_signed_a(op_q)),
    .b_signed_i(ebam_signed_b(op_q)),
    .fractional_i(ebam_is_fraction(op_q)),
    .product_o(product),
    .carry_o(prod_carry)
  );

  // result and flag selection per operation
  always_comb
  begin
    res_d = {8'h00, r8};
    flg_d = flags_q;
    wb8 = 1'b1;
    wb16 = 1'b0;
    upd_zn = 1'b1;
    keep_z = 1'b0;
    case (op_q)
      OP_ADD, OP_ADD_CARRY:
      begin
        flg_d[FLG_C] = sum9[8];
        flg_d[FLG_H] = h_bit;
        flg_d[FLG_V] = v_bit;
      end
      OP_SUBTRACT, OP_SUBTRACT_CONSTANT,
      OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW:
      begin
        flg_d[FLG_C] = sum9[8];
        flg_d[FLG_H] = h_bit;
        flg_d[FLG_V] = v_bit;
        keep_z = use_cin;
      end
      OP_SIGN_FLIP:
      begin
        flg_d[FLG_C] = (r8 != RST_BYTE);
        flg_d[FLG_H] = r8[3] | opa_q[3];
        flg_d[FLG_V] = (r8 == MIN_SIGNED);
      end
      OP_BITWISE_INVERT:
      begin
        res_d = {8'h00, 8'(ALL_ONES - opa_q)};
        flg_d[FLG_C] = 1'b1;
        flg_d[FLG_V] = 1'b0;
      end
      OP_WORD_ADD_IMMEDIATE, OP_WORD_SUBTRACT_IMMEDIATE:
      begin
        res_d = w16;
        wb8 = 1'b0;
        wb16 = 1'b1;
        upd_zn = 1'b0;
        flg_d[FLG_Z] = (w16 == 16'h0000);
        flg_d[FLG_N] = w16[15];
        flg_d[FLG_C] = w_c;
        flg_d[FLG_V] = w_v;
        flg_d[FLG_S] = w16[15] ^ w_v;
      end
      OP_AND, OP_AND_CONSTANT:
      begin
        res_d = {8'h00, opa_q & opb_q};
        flg_d[FLG_V] = 1'b0;
      end
      OP_SELF_AND_TEST:
      begin
        res_d = {8'h00, opa_q & opa_q};
        wb8 = 1'b0;
        flg_d[FLG_V] = 1'b0;
      end
      OP_OR, OP_OR_CONSTANT, OP_SET_BITS_BY_MASK:
      begin
        res_d = {8'h00, opa_q | opb_q};
        flg_d[FLG_V] = 1'b0;
      end
      OP_EXCLUSIVE_OR:
      begin
        res_d = {8'h00, opa_q ^ opb_q};
        flg_d[FLG_V] = 1'b0;
      end
      OP_ZERO_REGISTER:
      begin
        res_d = {8'h00, opa_q ^ opa_q};
        flg_d[FLG_V] = 1'b0;
      end
      OP_CLEAR_BITS_BY_MASK:
      begin
        res_d = {8'h00, opa_q & 8'(ALL_ONES - opb_q)};
        flg_d[FLG_V] = 1'b0;
      end
      OP_INCREMENT:
        flg_d[FLG_V] = (r8 == MIN_SIGNED);
      OP_MINUS_ONE:
        flg_d[FLG_V] = (r8 == POS_LIMIT);
      OP_FILL_ONES:
      begin
        res_d = {8'h00, ALL_ONES};
        upd_zn = 1'b0;
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT:
      begin
        res_d = product;
        wb8 = 1'b0;
        upd_zn = 1'b0;
        flg_d[FLG_Z] = (product == 16'h0000);
        flg_d[FLG_C] = prod_carry;
      end
      default:
      begin
        res_d = result_q;
        wb8 = 1'b0;
        upd_zn = 1'b0;
      end
    endcase
    if (upd_zn)
    begin
      // borrow chains keep z low once any byte was nonzero
      flg_d[FLG_Z] = (res_d[7:0] == RST_BYTE) &
                     (~keep_z | flags_q[FLG_Z]);
      flg_d[FLG_N] = res_d[7];
    end
  end

  // sequencing of the bus answer and the execution cycles
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    wait_d = avs_waitrequest_o;
    case (state_q)
      ST_IDLE:
      begin
        if (!avs_waitrequest_o)
          wait_d = 1'b1;
        else if (cmd_start)
        begin
          state_d = ST_EXEC;
          cnt_d = 2'(ebam_cycles(new_op) - 2'h1);
        end
        else if (accept)
          wait_d = 1'b0;
      end
      ST_EXEC:
      begin
        if (commit)
        begin
          state_d = ST_IDLE;
          wait_d = 1'b0;
        end
        else
          cnt_d = 2'(cnt_q - 2'h1);
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  assign rd_mux = (avs_address_i == REG_OPA) ? {24'h0, opa_q} :
                  (avs_address_i == REG_OPB) ? {24'h0, opb_q} :
                  (avs_address_i == REG_OPA_HI) ? {24'h0, opa_hi_q} :
                  (avs_address_i == REG_CMD) ? {27'h0, op_q} :
                  (avs_address_i == REG_RESULT) ? {16'h0, result_q} :
                  (avs_address_i == REG_FLAGS) ? {26'h0, flags_q} :
                  '0;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      op_q <= OP_ADD;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      avs_waitrequest_o <= wait_d;
      if (cmd_start)
        op_q <= new_op;
      if (accept && avs_read_i)
        avs_readdata_o <= rd_mux;
    end
  end

  // operand, result and flag storage; commit writes back like a destination
  always_ff @(posedge sys_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      opa_q <= RST_BYTE;
      opb_q <= RST_BYTE;
      opa_hi_q <= RST_BYTE;
      flags_q <= RST_FLAGS;
      result_q <= 16'h0000;
    end
    else if (commit)
    begin
      result_q <= res_d;
      flags_q <= flg_d;
      if (wb8 || wb16)
        opa_q <= res_d[7:0];
      if (wb16)
        opa_hi_q <= res_d[15:8];
    end
    else if (finish_wr)
    begin
      if (avs_address_i == REG_OPA)
        opa_q <= avs_writedata_i[7:0];
      if (avs_address_i == REG_OPB)
        opb_q <= avs_writedata_i[7:0];
      if (avs_address_i == REG_OPA_HI)
        opa_hi_q <= avs_writedata_i[7:0];
      if (avs_address_i == REG_FLAGS)
        flags_q <= avs_writedata_i[FLAGS_W-1:0];
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_issue_product;
    cmd_start && ebam_is_product(new_op);
  endsequence
  sequence s_issue_word;
    cmd_start && ebam_is_word(new_op);
  endsequence
  sequence s_two_cycle_finish;
    !commit ##1 commit ##1 !avs_waitrequest_o;
  endsequence
  a_single_cycle_ops: assert property (
    cmd_start && (ebam_cycles(new_op) == CYC_SINGLE) |=> commit
    ##1 !avs_waitrequest_o)
    else $error("single cycle op did not finish in one cycle");
  a_product_latency: assert property (
    s_issue_product |=> s_two_cycle_finish)
    else $error("product did not take two cycles");
  a_word_latency: assert property (
    s_issue_word |=> s_two_cycle_finish)
    else $error("word op did not take two cycles");
  a_sub_result: assert property (
    commit && (op_q == OP_SUBTRACT) |=>
    result_q[7:0] == 8'($past(opa_q) - $past(opb_q)))
    else $error("subtract result wrong");
  a_frac_shift: assert property (
    commit && (op_q == OP_FRACTIONAL_UNSIGNED_PRODUCT) |=>
    result_q == 16'(({8'h00, $past(opa_q)} * {8'h00, $past(opb_q)}) << 1))
    else $error("fractional product not shifted");
  a_step_keeps_carry: assert property (
    commit && step |=> flags_q[FLG_C] == $past(flags_q[FLG_C]))
    else $error("increment or decrement touched carry");
  a_mask_clear: assert property (
    commit && (op_q == OP_CLEAR_BITS_BY_MASK) |=>
    opa_q == ($past(opa_q) & ~$past(opb_q)))
    else $error("clear by mask wrong");
  a_test_keeps_reg: assert property (
    commit && (op_q == OP_SELF_AND_TEST) |=> $stable(opa_q) &&
    flags_q[FLG_Z] == (opa_q == 8'h00) && !flags_q[FLG_V])
    else $error("test changed register or flags wrong");
  a_fill_no_flags: assert property (
    commit && (op_q == OP_FILL_ONES) |=> $stable(flags_q) &&
    opa_q == ALL_ONES)
    else $error("fill ones touched flags");
  a_and_clears_v: assert property (
    commit && (op_q == OP_AND) |=> !flags_q[FLG_V] &&
    flags_q[FLG_C] == $past(flags_q[FLG_C]))
    else $error("and flags wrong");
endmodule
`default_nettype wire

// ==== verif/ebam_bus_master.sv ====
// Purpose: avalon-mm master standing in for the decoder and register file
// Assumes: one clock; the slave ends each access by dropping waitrequest
// Notes: released lines show inverted values so stale data cannot pass
`default_nettype none
module ebam_bus_master (
  input wire logic sys_clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [ebam_pkg::BUS_W-1:0] avs_readdata_i,
  output logic [ebam_pkg::ADDR_W-1:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [ebam_pkg::BUS_W-1:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ebam_pkg::*;

  initial
  begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = '0;
    avs_byteenable_o = 4'h0;
  end

  // no cycle count is assumed; only the bench watchdog ends a stuck wait
  task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [BUS_W-1:0] wd, input logic [3:0] be,
                        output logic [BUS_W-1:0] rd, output int edges);
    edges = 0;
    @(posedge sys_clk_i);
    avs_address_o <= addr;
    avs_writedata_o <= wd;
    avs_byteenable_o <= be;
    avs_read_o <= !wr;
    avs_write_o <= wr;
    do
    begin
      @(posedge sys_clk_i);
      edges++;
    end
    while (avs_waitrequest_i !== 1'b0);
    rd = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_address_o <= ~addr;
    avs_writedata_o <= ~wd;
    avs_byteenable_o <= ~be;
  endtask
endmodule
`default_nettype wire

// ==== verif/eight_bit_alu_multiplier_test.sv ====
// Purpose: self-checking bench of the alu and multiplier datapath
// Assumes: flags are preset before each op so kept flags show up
// Notes: vector is {a, a_hi, b, flags in, result, flags out}
`default_nettype none
module eight_bit_alu_multiplier_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ebam_pkg::*;

  logic sys_clk_i;
  logic sys_rst_i;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [BUS_W-1:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [BUS_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [BUS_W-1:0] d;
  int n;
  int fail_count;
  int checks_done;

  ebam_alu dut (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address),
    .avs_read_i(avs_read),
    .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable),
    .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest)
  );

  ebam_bus_master host (
    .sys_clk_i(sys_clk_i),
    .avs_waitrequest_i(avs_waitrequest),
    .avs_readdata_i(avs_readdata),
    .avs_address_o(avs_address),
    .avs_read_o(avs_read),
    .avs_write_o(avs_write),
    .avs_writedata_o(avs_writedata),
    .avs_byteenable_o(avs_byteenable)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
  end

  always #4 sys_clk_i = ~sys_clk_i;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    host.access(1'b1, a, {24'h0, v}, 4'hf, d, n);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    host.access(1'b0, a, 32'h0, 4'hf, d, n);
    chk($sformatf("reg %0h", a), d, exp);
  endtask

  task automatic run_op(input ebam_op_e op, input logic [55:0] v);
    logic prod;
    logic word;
    logic [7:0] opa;
    prod = (op >= OP_UNSIGNED_PRODUCT);
    word = (op == OP_WORD_ADD_IMMEDIATE);
    word = word || (op == OP_WORD_SUBTRACT_IMMEDIATE);
    // products and test leave the destination alone
    opa = (prod || op == OP_SELF_AND_TEST) ? v[55:48] : v[15:8];
    wr(REG_OPA, v[55:48]);
    wr(REG_OPA_HI, v[47:40]);
    wr(REG_OPB, v[39:32]);
    wr(REG_FLAGS, v[31:24]);
    host.access(1'b1, REG_CMD, {27'h0, op}, 4'hf, d, n);
    chk("cycles", 32'(n), (prod || word) ? 32'h4 : 32'h3);
    rd(REG_RESULT, {16'h0, v[23:8]});
    rd(REG_FLAGS, {26'h0, v[5:0]});
    rd(REG_OPA, {24'h0, opa});
    rd(REG_OPA_HI, {24'h0, word ? v[23:16] : v[47:40]});
    rd(REG_CMD, {27'h0, op});
  endtask

  initial
  begin
    @(negedge sys_rst_i);
    for (int i = 0; i < 6; i++)
      rd(5'(i * 4), 32'h0);
    run_op(OP_ADD, 56'h7f_00_01_10_0080_3c);
    run_op(OP_ADD_CARRY, 56'hff_00_00_01_0000_23);
    run_op(OP_WORD_ADD_IMMEDIATE, 56'hff_7f_01_30_8000_2c);
    run_op(OP_SUBTRACT, 56'h00_00_01_00_00ff_25);
    run_op(OP_SUBTRACT_CONSTANT, 56'h80_00_01_00_007f_28);
    run_op(OP_SUBTRACT_WITH_BORROW, 56'h10_00_0f_03_0000_22);
    run_op(OP_SUBTRACT_CONSTANT_WITH_BORROW, 56'h10_00_0f_01_0000_20);
    run_op(OP_WORD_SUBTRACT_IMMEDIATE, 56'h00_00_01_00_ffff_15);
    run_op(OP_AND, 56'hf0_00_8f_39_0080_35);
    run_op(OP_AND_CONSTANT, 56'h0f_00_f0_08_0000_02);
    run_op(OP_OR, 56'h80_00_01_01_0081_05);
    run_op(OP_OR_CONSTANT, 56'h00_00_00_00_0000_02);
    run_op(OP_EXCLUSIVE_OR, 56'haa_00_55_20_00ff_24);
    run_op(OP_BITWISE_INVERT, 56'h55_00_00_28_00aa_25);
    run_op(OP_SIGN_FLIP, 56'h80_00_00_20_0080_0d);
    run_op(OP_SET_BITS_BY_MASK, 56'h01_00_80_00_0081_04);
    run_op(OP_CLEAR_BITS_BY_MASK, 56'hff_00_0f_01_00f0_05);
    run_op(OP_INCREMENT, 56'h7f_00_00_01_0080_0d);
    run_op(OP_MINUS_ONE, 56'h80_00_00_00_007f_08);
    run_op(OP_SELF_AND_TEST, 56'h80_00_00_08_0080_04);
    run_op(OP_ZERO_REGISTER, 56'h5a_00_00_0c_0000_02);
    run_op(OP_FILL_ONES, 56'h00_00_00_2a_00ff_2a);
    run_op(OP_UNSIGNED_PRODUCT, 56'hff_00_ff_06_fe01_05);
    run_op(OP_SIGNED_PRODUCT, 56'h80_00_80_01_4000_00);
    run_op(OP_MIXED_SIGN_PRODUCT, 56'hff_00_82_00_ff7e_01);
    run_op(OP_FRACTIONAL_UNSIGNED_PRODUCT, 56'h80_00_80_02_8000_00);
    run_op(OP_FRACTIONAL_SIGNED_PRODUCT, 56'hc0_00_40_00_e000_01);
    run_op(OP_FRACTIONAL_MIXED_PRODUCT, 56'h00_00_55_01_0000_02);
    // upper bus bits are dropped by the byte registers
    host.access(1'b1, REG_OPB, 32'hffff_ff5a, 4'hf, d, n);
    rd(REG_OPB, 32'h0000_005a);
    wr(5'h18, 8'hff);
    rd(5'h18, 32'h0);
    wr(REG_RESULT, 8'h34);
    rd(REG_RESULT, 32'h0);
    // a command write without its low byte lane must not start
    host.access(1'b1, REG_CMD, {27'h0, OP_FILL_ONES}, 4'h0, d, n);
    rd(REG_OPA, 32'h0);
    rd(REG_CMD, {27'h0, OP_FRACTIONAL_MIXED_PRODUCT});
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    $display("watchdog expired before the tests ended");
    end_of_test();
  end
endmodule
`default_nettype wire
